/* File: core/plmc_ctrl.sv */
// host-side controller: mode register update, sleep entry/exit and page pacing for a psram
`timescale 1ns/1ps
// Notes on behaviour
// - stored setting reused; change needs update
// - no access outside reduced region; not checked here, left to the user
// - deselect 5ns before sleep falls
// - register write timings at least grade
// - sleep pulse 10us, recovery 200us
// - page cycle between 20ns and 20k ns
module plmc_ctrl
  import plmc_pkg::*;
#(
  parameter int unsigned SLEEP_PULSE_CYC = SLEEP_MIN_PULSE_CYC,
  parameter int unsigned RECOVERY_CYC    = SLEEP_RECOVERY_CYC
)(
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              resetn_in,
  // user command port
  input  wire logic              cmd_valid_in,
  input  wire plmc_pkg::plmc_cmd_t cmd_in,
  input  wire logic [2:0]        cmd_region_in,
  input  wire logic              cmd_size_sel_in,
  input  wire logic              cmd_partial_en_in,
  input  wire logic [1:0]        cmd_temp_in,
  input  wire logic              cmd_page_en_in,
  input  wire logic              sleep_hold_in,
  input  wire logic [plmc_pkg::ADDR_W-1:0] cmd_addr_in,
  output logic                   cmd_ready_out,
  output logic                   cmd_done_out,
  output logic                   cmd_error_out,
  output logic [7:0]             mode_shadow_out,
  output logic                   asleep_out,
  // device pins
  output logic                   ce_n_out,
  output logic                   we_n_out,
  output logic                   sleep_request_n_out,
  output logic [plmc_pkg::ADDR_W-1:0] addr_out
);
  import plmc_pkg::*;

  // the delay timer is only CNT_W bits wide, so longer waits cannot be served
  if (SLEEP_PULSE_CYC < 1 || SLEEP_PULSE_CYC >= (1 << CNT_W) ||
      RECOVERY_CYC < 1 || RECOVERY_CYC >= (1 << CNT_W)) begin : g_bad_timing
    $error("plmc_ctrl: timing parameter out of counter range");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n);
  endfunction

  function automatic logic region_reserved(input logic [2:0] r);
    region_reserved = (r == REGION_RSVD_A) || (r == REGION_RSVD_B);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  plmc_state_t       state_ff, nxt_state;
  plmc_cmd_t         cmd_in_hold_ff;
  logic              ce_n_ff, we_n_ff, zz_n_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0]        mode_ff;
  logic              ready_ff, done_ff, err_ff, asleep_ff;
  logic [ADDR_W-1:0] page_addr_ff;

  plmc_timer_if tif ();
  plmc_timer u_timer (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .tmr        (tif.timer)
  );

  logic accept;
  assign accept = cmd_valid_in && ready_ff && (state_ff == PLMC_IDLE);

  logic bad_cmd;
  // reserved region codes with cmd_partial_en_in set are refused rather than sent to the device
  assign bad_cmd = (cmd_in == PLMC_CMD_SET_MODE) && cmd_partial_en_in && region_reserved(cmd_region_in);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    tif.load  = 1'b0;
    tif.count = '0;
    case (state_ff)
      PLMC_IDLE: begin
        if (accept && !bad_cmd) begin
          tif.load = 1'b1;
          if (cmd_in == PLMC_CMD_PAGE_CYCLE) begin
            nxt_state = PLMC_PAGE;
            tif.count = cyc(PAGE_CYCLE_CYC);
          end else begin
            nxt_state = PLMC_DESEL;
            tif.count = cyc(DESELECT_TO_SLEEP_CYC);
          end
        end
      end
      PLMC_DESEL: begin
        if (tif.expired) begin
          tif.load  = 1'b1;
          nxt_state = PLMC_ZZ_LOW;
          tif.count = (cmd_in_hold_ff == PLMC_CMD_SLEEP) ? cyc(SLEEP_PULSE_CYC) : cyc(SLEEP_TO_WRITE_CYC);
        end
      end
      PLMC_ZZ_LOW: begin
        if (tif.expired) begin
          tif.load = 1'b1;
          if (cmd_in_hold_ff == PLMC_CMD_SLEEP) begin
            nxt_state = PLMC_SLEEP;
          end else begin
            // we falls within the 10..500ns window after sleep falls
            nxt_state = PLMC_WR_PULSE;
            tif.count = cyc(REG_WRITE_CYC);
          end
        end
      end
      PLMC_WR_PULSE: begin
        if (tif.expired) begin
          nxt_state = PLMC_WR_DONE;
        end
      end
      PLMC_WR_DONE: begin
        nxt_state = PLMC_IDLE;
      end
      PLMC_SLEEP: begin
        // sleep pulse already met its minimum; stay while user holds
        if (!sleep_hold_in) begin
          tif.load  = 1'b1;
          tif.count = cyc(RECOVERY_CYC);
          nxt_state = PLMC_RECOVER;
        end
      end
      PLMC_RECOVER: begin
        if (tif.expired) begin
          nxt_state = PLMC_IDLE;
        end
      end
      PLMC_PAGE: begin
        if (tif.expired) begin
          nxt_state = PLMC_IDLE;
        end
      end
      default: begin
        nxt_state = PLMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff       <= PLMC_IDLE;
      cmd_in_hold_ff <= PLMC_CMD_SET_MODE;
    end else begin
      state_ff <= nxt_state;
      if (accept) begin
        cmd_in_hold_ff <= cmd_in;
      end
    end
  end

  // ------------------------------------------------------------
  // device pins
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      zz_n_ff <= 1'b1;
      addr_ff <= '0;
    end else begin
      ce_n_ff <= !(nxt_state == PLMC_WR_PULSE || nxt_state == PLMC_PAGE); // deselect before sleep
      we_n_ff <= !(nxt_state == PLMC_WR_PULSE);
      // sleep rise ends deep sleep or partial refresh and applies reduced size
      zz_n_ff <= !(nxt_state == PLMC_ZZ_LOW || nxt_state == PLMC_WR_PULSE || nxt_state == PLMC_SLEEP);
      if (accept && !bad_cmd) begin
        if (cmd_in == PLMC_CMD_SET_MODE) begin
          // register value travels on the address pins
          addr_ff <= {{(ADDR_W-8){1'b0}}, cmd_page_en_in, cmd_temp_in, cmd_partial_en_in,
                      cmd_size_sel_in, cmd_region_in};
        end else begin
          addr_ff <= cmd_addr_in;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // shadow of programmed mode and status
  // ------------------------------------------------------------
  // shadow resets with sleep-select one; device keeps setting until next update
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_ff <= MODE_RESET;
    end else if (state_ff == PLMC_WR_DONE) begin
      mode_ff <= addr_ff[7:0];
    end
  end

  // a page command while page mode is off is flagged as an error but still run; accesses beyond a
  // reduced region are the user's responsibility, no range check here
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_ff  <= 1'b0;
      done_ff   <= 1'b0;
      err_ff    <= 1'b0;
      asleep_ff <= 1'b0;
    end else begin
      ready_ff  <= (nxt_state == PLMC_IDLE) && !accept;
      done_ff   <= (state_ff == PLMC_WR_DONE) ||
                   ((state_ff == PLMC_RECOVER || state_ff == PLMC_PAGE) && nxt_state == PLMC_IDLE);
      err_ff    <= accept && (bad_cmd || (cmd_in == PLMC_CMD_PAGE_CYCLE && !mode_ff[PAGE_EN_BIT]));
      // partial refresh vs deep sleep is chosen by the device from the sleep-select bit
      asleep_ff <= (nxt_state == PLMC_SLEEP);
    end
  end

  assign cmd_ready_out       = ready_ff;
  assign cmd_done_out        = done_ff;
  assign cmd_error_out       = err_ff;
  assign mode_shadow_out     = mode_ff;
  assign asleep_out          = asleep_ff;
  assign ce_n_out            = ce_n_ff;
  assign we_n_out            = we_n_ff;
  assign sleep_request_n_out = zz_n_ff;
  assign addr_out            = addr_ff;
endmodule

/* File: core/plmc_timer.sv */
// delay timer: counts down a loaded cycle count and flags expiry
`timescale 1ns/1ps
module plmc_timer
  import plmc_pkg::*;
(
  // clock and reset
  input  wire logic  ref_clk_in,
  input  wire logic  resetn_in,
  // control
  plmc_timer_if.timer tmr
);
  logic [CNT_W-1:0] remain_ff;
  logic             expired_ff;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      remain_ff <= '0;
    end else if (tmr.load) begin
      remain_ff <= tmr.count;
    end else if (remain_ff != '0) begin
      remain_ff <= remain_ff - 1'b1;
    end
  end

  // expiry is a level so the controller may sample it late
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= !tmr.load && (remain_ff <= CNT_W'(1));
    end
  end

  assign tmr.expired = expired_ff;
endmodule

/* File: include/plmc_pkg.sv */
// package: constants and types for the psram low-power mode controller
package plmc_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS           = 40000;
  localparam int unsigned DESELECT_TO_SLEEP_NS    = 5;
  localparam int unsigned SLEEP_TO_WRITE_MIN_NS   = 10;
  localparam int unsigned SLEEP_TO_WRITE_MAX_NS   = 500;
  localparam int unsigned REG_WRITE_NS            = 85;
  localparam int unsigned SLEEP_MIN_PULSE_US      = 10;
  localparam int unsigned SLEEP_RECOVERY_US       = 200;
  localparam int unsigned PAGE_CYCLE_MIN_NS       = 20;
  // least times round up, longest times round down, never below one cycle
  localparam int unsigned DESELECT_TO_SLEEP_CYC =
    ((DESELECT_TO_SLEEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((DESELECT_TO_SLEEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned SLEEP_TO_WRITE_CYC =
    ((SLEEP_TO_WRITE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((SLEEP_TO_WRITE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned SLEEP_TO_WRITE_MAX_CYC  = SLEEP_TO_WRITE_MAX_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned REG_WRITE_CYC =
    (REG_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SLEEP_MIN_PULSE_CYC =
    (SLEEP_MIN_PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SLEEP_RECOVERY_CYC =
    (SLEEP_RECOVERY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PAGE_CYCLE_CYC =
    ((PAGE_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((PAGE_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned CNT_W = 16;
  // ------------------------------------------------------------
  // mode register fields (address bits captured by the device)
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W          = 22;
  localparam int unsigned REGION_LSB      = 0;
  localparam int unsigned REGION_W        = 3;
  localparam int unsigned SIZE_SEL_BIT    = 3;
  localparam int unsigned SLEEP_SEL_BIT   = 4;
  localparam int unsigned TEMP_LSB        = 5;
  localparam int unsigned TEMP_W          = 2;
  localparam int unsigned PAGE_EN_BIT     = 7;
  localparam logic [7:0] MODE_RESET       = 8'h10;
  localparam logic [2:0] REGION_TOP_QTR   = 3'h7;
  localparam logic [2:0] REGION_TOP_HALF  = 3'h6;
  localparam logic [2:0] REGION_NONE      = 3'h4;
  localparam logic [2:0] REGION_BOT_QTR   = 3'h3;
  localparam logic [2:0] REGION_BOT_HALF  = 3'h2;
  localparam logic [2:0] REGION_FULL      = 3'h0;
  localparam logic [2:0] REGION_RSVD_A    = 3'h5;
  localparam logic [2:0] REGION_RSVD_B    = 3'h1;
  localparam logic [1:0] TEMP_15C         = 2'h0;
  localparam logic [1:0] TEMP_45C         = 2'h1;
  localparam logic [1:0] TEMP_70C         = 2'h2;
  localparam logic [1:0] TEMP_85C         = 2'h3;
  // ------------------------------------------------------------
  // commands and states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PLMC_CMD_SET_MODE   = 2'h0,
    PLMC_CMD_SLEEP      = 2'h1,
    PLMC_CMD_PAGE_CYCLE = 2'h2
  } plmc_cmd_t;
  // gray codes along deselect -> sleep -> write -> release
  typedef enum logic [3:0] {
    PLMC_IDLE     = 4'h0,
    PLMC_DESEL    = 4'h1,
    PLMC_ZZ_LOW   = 4'h3,
    PLMC_WR_PULSE = 4'h2,
    PLMC_WR_DONE  = 4'h6,
    PLMC_SLEEP    = 4'h7,
    PLMC_RECOVER  = 4'h5,
    PLMC_PAGE     = 4'h4
  } plmc_state_t;
endpackage

/* File: include/plmc_timer_if.sv */
// interface: load/expire handshake between controller and its delay timer
`timescale 1ns/1ps
interface plmc_timer_if;
  import plmc_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic             expired;
  modport ctrl  (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface

/* File: sim/plmc_ctrl_chk.sv */
// checker: pin timing and response assertions on the controller ports
`timescale 1ns/1ps
module plmc_ctrl_chk
  import plmc_pkg::*;
#(
  parameter int unsigned SLEEP_PULSE_CYC = 4,
  parameter int unsigned RECOVERY_CYC    = 8
)(
  // clock and reset
  input wire logic                        ref_clk_in,
  input wire logic                        resetn_in,
  // user command port
  input wire logic                        cmd_valid_in,
  input wire plmc_pkg::plmc_cmd_t         cmd_in,
  input wire logic [2:0]                  cmd_region_in,
  input wire logic                        cmd_size_sel_in,
  input wire logic                        cmd_partial_en_in,
  input wire logic [1:0]                  cmd_temp_in,
  input wire logic                        cmd_page_en_in,
  input wire logic                        sleep_hold_in,
  input wire logic [plmc_pkg::ADDR_W-1:0] cmd_addr_in,
  // controller status
  input wire logic                        cmd_ready_out,
  input wire logic                        cmd_done_out,
  input wire logic                        cmd_error_out,
  input wire logic [7:0]                  mode_shadow_out,
  input wire logic                        asleep_out,
  // device pins
  input wire logic                        ce_n_out,
  input wire logic                        we_n_out,
  input wire logic                        sleep_request_n_out,
  input wire logic [plmc_pkg::ADDR_W-1:0] addr_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [15:0] low_cnt_ff, rec_cnt_ff;
  logic [7:0]  wr_addr_ff;
  logic        took, rsvd;
  assign took = cmd_valid_in && cmd_ready_out;
  assign rsvd = cmd_partial_en_in && (cmd_region_in == REGION_RSVD_A || cmd_region_in == REGION_RSVD_B);
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) low_cnt_ff <= 16'h0;
    else low_cnt_ff <= sleep_request_n_out ? 16'h0 : low_cnt_ff + 16'h1;
  end
  // saturating, so a long idle never wraps into a false recovery window
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) rec_cnt_ff <= 16'hFFFF;
    else if (asleep_out && !sleep_request_n_out) rec_cnt_ff <= 16'h0;
    else if (rec_cnt_ff != 16'hFFFF) rec_cnt_ff <= rec_cnt_ff + 16'h1;
  end
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) wr_addr_ff <= 8'h10;
    else if (!we_n_out && !ce_n_out && !sleep_request_n_out) wr_addr_ff <= addr_out[7:0];
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  a_desel_first: assert property ($fell(sleep_request_n_out) |-> ce_n_out && $past(ce_n_out))
    else $error("sleep pin fell while selected");
  a_we_late: assert property ($fell(we_n_out) && !sleep_request_n_out |-> $past(sleep_request_n_out) == 1'b0)
    else $error("write enable fell with sleep pin");
  a_write_len: assert property ($fell(we_n_out) && !sleep_request_n_out |-> (!we_n_out && !ce_n_out) [*3])
    else $error("register write too short");
  a_pulse_min: assert property ($rose(sleep_request_n_out) && $past(asleep_out) |-> low_cnt_ff >= SLEEP_PULSE_CYC)
    else $error("sleep pulse too short");
  a_recover_wait: assert property ($fell(ce_n_out) |-> rec_cnt_ff >= RECOVERY_CYC - 2)
    else $error("access inside recovery");
  a_rsvd_quiet: assert property (took && cmd_in == PLMC_CMD_SET_MODE && rsvd |=> sleep_request_n_out [*3])
    else $error("pins moved on reserved code");
  a_rsvd_flag: assert property (took && cmd_in == PLMC_CMD_SET_MODE && rsvd |-> ##[1:3] cmd_error_out)
    else $error("reserved code not flagged");
  a_page_flag: assert property (took && cmd_in == PLMC_CMD_PAGE_CYCLE && !mode_shadow_out[7] |-> ##[1:4] cmd_error_out)
    else $error("disabled page cycle not flagged");
  a_page_span: assert property ($fell(ce_n_out) && we_n_out |-> ##[1:500] ce_n_out)
    else $error("page cycle held too long");
  a_shadow_src: assert property ($changed(mode_shadow_out) |-> mode_shadow_out == wr_addr_ff)
    else $error("shadow differs from written address");
  a_asleep_pin: assert property (asleep_out |-> !sleep_request_n_out)
    else $error("asleep with sleep pin high");
endmodule
bind plmc_ctrl plmc_ctrl_chk #(.SLEEP_PULSE_CYC(SLEEP_PULSE_CYC), .RECOVERY_CYC(RECOVERY_CYC)) chk_u (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .cmd_region_in(cmd_region_in), .cmd_size_sel_in(cmd_size_sel_in), .cmd_partial_en_in(cmd_partial_en_in),
  .cmd_temp_in(cmd_temp_in), .cmd_page_en_in(cmd_page_en_in), .sleep_hold_in(sleep_hold_in),
  .cmd_addr_in(cmd_addr_in), .addr_out(addr_out), .cmd_ready_out(cmd_ready_out), .cmd_done_out(cmd_done_out),
  .cmd_error_out(cmd_error_out), .mode_shadow_out(mode_shadow_out), .asleep_out(asleep_out),
  .ce_n_out(ce_n_out), .we_n_out(we_n_out), .sleep_request_n_out(sleep_request_n_out));

/* File: sim/plmc_ctrl_tb.sv */
// testbench: mode controller against a behavioural psram
`timescale 1ns/1ps
module plmc_ctrl_tb;
  import plmc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              ref_clk_in, resetn_in, cmd_valid_in, cmd_size_sel_in, cmd_partial_en_in;
  logic              cmd_page_en_in, sleep_hold_in, err, rsvd;
  plmc_cmd_t         cmd_in;
  logic [2:0]        cmd_region_in;
  logic [1:0]        cmd_temp_in;
  logic [ADDR_W-1:0] cmd_addr_in, addr_out;
  logic              cmd_ready_out, cmd_done_out, cmd_error_out, asleep_out;
  logic              ce_n_out, we_n_out, sleep_request_n_out, dev_deep, dev_partial;
  logic [7:0]        mode_shadow_out, dev_mode, v, exp_mode;
  logic [31:0]       rng;
  int                fails, checks_done, cyc;
  plmc_ctrl #(.SLEEP_PULSE_CYC(4), .RECOVERY_CYC(8)) dut_u (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_region_in(cmd_region_in), .cmd_size_sel_in(cmd_size_sel_in), .cmd_partial_en_in(cmd_partial_en_in),
    .cmd_temp_in(cmd_temp_in), .cmd_page_en_in(cmd_page_en_in), .sleep_hold_in(sleep_hold_in),
    .cmd_addr_in(cmd_addr_in), .cmd_ready_out(cmd_ready_out), .cmd_done_out(cmd_done_out),
    .cmd_error_out(cmd_error_out), .mode_shadow_out(mode_shadow_out), .asleep_out(asleep_out),
    .ce_n_out(ce_n_out), .we_n_out(we_n_out), .sleep_request_n_out(sleep_request_n_out), .addr_out(addr_out));
  plmc_psram_model #(.ENTRY_CYC(12)) dev_u (
    .ref_clk_in(ref_clk_in), .ce_n_in(ce_n_out), .we_n_in(we_n_out), .sleep_request_n_in(sleep_request_n_out),
    .addr_in(addr_out), .mode_reg_out(dev_mode), .deep_out(dev_deep), .partial_out(dev_partial));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // page addresses stay inside a reduced region while one is programmed
  function automatic logic [ADDR_W-1:0] keep_addr(input logic [7:0] m, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = a;
    if (m[4] && m[3] && m[1]) begin
      r[21] = 1'b0;
      r[20] = m[2];
      if (m[0]) r[19] = m[2];
    end
    return r;
  endfunction
  task automatic close_out;
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // request held until the edge that samples ready high
  task automatic run(input plmc_cmd_t c, input logic [7:0] f, input int hold, output logic e);
    int n;
    logic d;
    e = 1'b0;
    d = 1'b0;
    n = 0;
    cmd_in <= c;
    {cmd_page_en_in, cmd_temp_in, cmd_partial_en_in, cmd_size_sel_in, cmd_region_in} <= f;
    cmd_addr_in <= keep_addr(f, rng[ADDR_W-1:0]);
    cmd_valid_in <= 1'b1;
    sleep_hold_in <= (hold > 0);
    do @(posedge ref_clk_in); while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 1'b0;
    while (n < 300) begin
      @(posedge ref_clk_in);
      n++;
      if (cmd_error_out === 1'b1) e = 1'b1;
      if (n == hold) begin
        chk("asleep", 8'h01, 8'(asleep_out));
        chk("deep", 8'(!exp_mode[4]), 8'(dev_deep));
        chk("partial", 8'(exp_mode[4] && exp_mode[2:0] != REGION_NONE), 8'(dev_partial));
        sleep_hold_in <= 1'b0;
      end
      if (cmd_done_out === 1'b1) d = 1'b1;
      if (d || (e && c == PLMC_CMD_SET_MODE)) break;
    end
    chk("finished", 8'h01, 8'(d || (e && c == PLMC_CMD_SET_MODE)));
    @(posedge ref_clk_in);
  endtask
  // ----------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    {resetn_in, cmd_valid_in, cmd_size_sel_in, cmd_partial_en_in, cmd_page_en_in, sleep_hold_in} = 6'h00;
    {cmd_region_in, cmd_temp_in, cmd_addr_in} = '0;
    cmd_in = PLMC_CMD_SET_MODE;
    fails = 0;
    checks_done = 0;
    cyc = 0;
    rng = 32'h0000AE49;
    exp_mode = 8'h10;
    repeat (16) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    chk("shadow", 8'h10, mode_shadow_out);
    run(PLMC_CMD_PAGE_CYCLE, exp_mode, 0, err);
    chk("page_err", 8'h01, 8'(err));
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      v = {rng[7], i[1:0], (i < 8) | i[2], rng[3], i[2:0]};
      rsvd = v[4] && (v[2:0] == REGION_RSVD_A || v[2:0] == REGION_RSVD_B);
      run(PLMC_CMD_SET_MODE, v, 0, err);
      if (!rsvd) exp_mode = v;
      chk("set_err", 8'(rsvd), 8'(err));
      chk("shadow", exp_mode, mode_shadow_out);
      chk("dev_mode", exp_mode, dev_mode);
      if (i[1:0] == 2'h3) begin
        run(PLMC_CMD_SLEEP, exp_mode, 20, err);
        chk("wake", 8'h00, {6'h0, dev_deep, dev_partial});
        chk("dev_mode", exp_mode, dev_mode);
      end
      rng = xs(rng);
      run(PLMC_CMD_PAGE_CYCLE, exp_mode, 0, err);
      chk("page_err", 8'(!exp_mode[7]), 8'(err));
    end
    close_out;
  end
endmodule

/* File: sim/plmc_psram_model.sv */
// partner: behavioural psram mode register and low-power state
`timescale 1ns/1ps
module plmc_psram_model
  import plmc_pkg::*;
#(
  parameter int unsigned ENTRY_CYC = 12
)(
  // bus pins
  input  wire logic              ref_clk_in,
  input  wire logic              ce_n_in,
  input  wire logic              we_n_in,
  input  wire logic              sleep_request_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  // observed state
  output logic [7:0]             mode_reg_out,
  output logic                   deep_out,
  output logic                   partial_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  // entry delay scaled down; a register write never stays low this long
  int low_cyc = 0;
  initial begin
    mode_reg_out = 8'h10; // deep sleep off by default
    deep_out = 1'b0;
    partial_out = 1'b0;
  end
  always @(posedge ref_clk_in) begin
    if (!sleep_request_n_in && !ce_n_in && !we_n_in) begin
      mode_reg_out <= addr_in[7:0]; // address levels only, kept for later standby
    end
    low_cyc = sleep_request_n_in ? 0 : low_cyc + 1;
    if (sleep_request_n_in) begin
      deep_out <= 1'b0;
      partial_out <= 1'b0;
    end else if (low_cyc == ENTRY_CYC) begin
      deep_out <= !mode_reg_out[SLEEP_SEL_BIT];
      partial_out <= mode_reg_out[SLEEP_SEL_BIT] && mode_reg_out[2:0] != REGION_NONE;
    end
  end
endmodule
